//--- core/cal_pkg.sv
// constants and carrier types of the calibration datapath
package cal_pkg;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [9:0] IDX_PHASE_A    = 10'h108;
	localparam logic [9:0] IDX_PHASE_B    = 10'h109;
	localparam logic [9:0] IDX_IGAIN_A    = 10'h280;
	localparam logic [9:0] IDX_VGAIN_1    = 10'h281;
	localparam logic [9:0] IDX_WGAIN_A    = 10'h282;
	localparam logic [9:0] IDX_VARGAIN_A  = 10'h283;
	localparam logic [9:0] IDX_VAGAIN_A   = 10'h284;
	localparam logic [9:0] IDX_IRMSOS_A   = 10'h286;
	localparam logic [9:0] IDX_VOLTAGE_RMS_OFFSET     = 10'h288;
	localparam logic [9:0] IDX_WOS_A      = 10'h289;
	localparam logic [9:0] IDX_VAROS_A    = 10'h28a;
	localparam logic [9:0] IDX_VAOS_A     = 10'h28b;
	localparam logic [9:0] IDX_IGAIN_B    = 10'h28c;
	localparam logic [9:0] IDX_VGAIN_2    = 10'h28d;
	localparam logic [9:0] IDX_WGAIN_B    = 10'h28e;
	localparam logic [9:0] IDX_VARGAIN_B  = 10'h28f;
	localparam logic [9:0] IDX_VAGAIN_B   = 10'h290;
	localparam logic [9:0] IDX_IRMSOS_B   = 10'h292;
	localparam logic [9:0] IDX_WOS_B      = 10'h295;
	localparam logic [9:0] IDX_VAROS_B    = 10'h296;
	localparam logic [9:0] IDX_VAOS_B     = 10'h297;
	localparam logic [9:0] IDX_STATUS     = 10'h3f0;

	// ------------------------------------------------------------
	// reset values and arithmetic alignment
	// ------------------------------------------------------------
	localparam logic [23:0] GAIN_UNITY    = 24'h400000;
	localparam logic [23:0] OFS_RESET     = 24'h000000;
	localparam logic [9:0]  PHASE_RESET   = 10'h000;
	localparam int          GAIN_SHIFT    = 22;
	localparam int          POW_OFS_SHIFT = 9;
	localparam int          RMS_OFS_SHIFT = 12;
	localparam int          PHASE_MSB     = 9;
	localparam logic [8:0]  PHASE_MAX     = 9'h17f;
	localparam int          PHASE_DEPTH   = 384;

	// ------------------------------------------------------------
	// phase trim step timing
	// ------------------------------------------------------------
	localparam int STEP_TIME_PS  = 1117000;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int STEP_CYCLES   = STEP_TIME_PS / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic signed [23:0] active;
		logic signed [23:0] reactive;
		logic signed [23:0] apparent;
	} power_t;

	typedef struct packed {
		logic [47:0] volt;
		logic [47:0] cur_a;
		logic [47:0] cur_b;
	} rms_sq_t;

	typedef struct packed {
		logic [23:0] volt;
		logic [23:0] cur_a;
		logic [23:0] cur_b;
	} rms_t;

	typedef struct packed {
		logic signed [23:0] cur_a;
		logic signed [23:0] cur_b;
		logic signed [23:0] volt;
	} wave_t;

endpackage : cal_pkg

//--- core/energy_meter_calibration.sv
// per-channel gain, offset and phase calibration datapath
//
// Function
// - calibrated active power equals raw power times gain over 0x400000
// - active gain words reset to 0x400000, unity gain
// - reactive and apparent powers scale by their own gain words likewise
// - channel A and channel B keep separate power coefficient sets
// - channel B current and its rms scale by channel B current gain
// - channel A current path scales by channel A current gain the same way
// - only first voltage gain affects voltage rms; software mirrors second
// - phase trim is 10-bit sign-magnitude; msb 0 delays, 1 advances
// - each phase trim step shifts the current by 139 clocks, 1.112 microseconds at 8 ns
// - active offset is 24-bit signed, reset zero, added right-shifted 9
// - reactive offset adds to reactive power like the active offset
// - apparent offset adds to apparent power like the active offset
// - voltage rms is root of squared value plus offset times 2^12
// - each current rms adds its own offset times 2^12 under the root
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
module energy_meter_calibration (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic [11:0]     address_i,
	input  wire logic            read_i,
	input  wire logic            write_i,
	input  wire logic [31:0]     writedata_i,
	input  wire logic [3:0]      byteenable_i,
	output logic      [31:0]     readdata_o,
	output logic                 waitrequest_o,
	input  wire cal_pkg::power_t power_a_i,
	input  wire cal_pkg::power_t power_b_i,
	input  wire logic            power_valid_i,
	output cal_pkg::power_t      power_a_o,
	output cal_pkg::power_t      power_b_o,
	output logic                 power_valid_o,
	input  wire cal_pkg::rms_sq_t rms_sq_i,
	input  wire logic            rms_valid_i,
	output cal_pkg::rms_t        rms_o,
	output logic                 rms_valid_o,
	input  wire cal_pkg::wave_t  wave_i,
	output cal_pkg::wave_t       wave_a_o,
	output cal_pkg::wave_t       wave_b_o,
	output logic                 wave_valid_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [9:0]  phase_a;
		logic [9:0]  phase_b;
		logic [23:0] igain_a;
		logic [23:0] vgain_1;
		logic [23:0] wgain_a;
		logic [23:0] vargain_a;
		logic [23:0] vagain_a;
		logic [23:0] irmsos_a;
		logic [23:0] voltage_rms_offset;
		logic [23:0] wos_a;
		logic [23:0] varos_a;
		logic [23:0] vaos_a;
		logic [23:0] igain_b;
		logic [23:0] vgain_2;
		logic [23:0] wgain_b;
		logic [23:0] vargain_b;
		logic [23:0] vagain_b;
		logic [23:0] irmsos_b;
		logic [23:0] wos_b;
		logic [23:0] varos_b;
		logic [23:0] vaos_b;
	} regs_t;

	typedef struct packed {
		regs_t           regs;
		logic            wait_n;
		logic [31:0]     rdata;
		cal_pkg::power_t pa;
		cal_pkg::power_t pb;
		logic            pvalid;
		cal_pkg::rms_t   rms;
		logic            rvalid;
		cal_pkg::wave_t  wa;
		cal_pkg::wave_t  wb;
		logic            wvalid;
		logic [7:0]      div;
		logic [8:0]      wp;
		logic [15:0]     pcount;
	} state_t;

	state_t      s_q;
	state_t      s_d;
	logic [71:0] hist [0:cal_pkg::PHASE_DEPTH-1];
	logic        tick;

	// ------------------------------------------------------------
	// arithmetic helpers
	// ------------------------------------------------------------
	// product truncated back to the raw width
	function automatic logic signed [23:0] gain_apply(
		input logic signed [23:0] raw,
		input logic [23:0]        gain
	);
		logic signed [48:0] prod;
		prod = raw * $signed({1'b0, gain});
		gain_apply = prod[cal_pkg::GAIN_SHIFT +: 24];
	endfunction : gain_apply

	// offset carries 9 fraction bits; saturate to 24-bit signed
	function automatic logic signed [23:0] offset_apply(
		input logic signed [23:0] p,
		input logic [23:0]        os
	);
		logic signed [33:0] sum;
		logic signed [24:0] whole;
		sum = ($signed({{1{p[23]}}, p}) <<< cal_pkg::POW_OFS_SHIFT)
			+ $signed({{10{os[23]}}, os});
		whole = sum[33:9];
		if (sum[33] == 1'b0 && sum[32:32] != 1'b0)
			offset_apply = 24'sh7fffff;
		else if (sum[33] == 1'b1 && sum[32:32] != 1'b1)
			offset_apply = -24'sh800000;
		else
			offset_apply = whole[23:0];
	endfunction : offset_apply

	// root of squared value plus offset times 2^12, then gain
	function automatic logic [23:0] rms_cal(
		input logic [47:0] sq,
		input logic [23:0] os,
		input logic [23:0] gain
	);
		logic signed [49:0] rad;
		logic [47:0]        r;
		logic [23:0]        root;
		logic [47:0]        scaled;
		rad = $signed({2'b00, sq}) + ($signed({{14{os[23]}}, os,
			12'h000}));
		if (rad[49])
			r = 48'h0;
		else if (rad[48])
			r = 48'hffffffffffff;
		else
			r = rad[47:0];
		root = 24'h0;
		for (int i = 23; i >= 0; i--) begin
			logic [23:0] t;
			t = root | (24'h1 << i);
			if ({24'h0, t} * {24'h0, t} <= r)
				root = t;
		end
		scaled = {24'h0, root} * {24'h0, gain};
		if (scaled[47:46] != 2'b00)
			rms_cal = 24'hffffff;
		else
			rms_cal = scaled[cal_pkg::GAIN_SHIFT +: 24];
	endfunction : rms_cal

	// merge byte lanes of a write into a 24-bit word
	function automatic logic [23:0] be_merge(
		input logic [23:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		be_merge = old;
		for (int i = 0; i < 3; i++) begin
			if (be[i])
				be_merge[i*8 +: 8] = wd[i*8 +: 8];
		end
	endfunction : be_merge

	// history slot a given number of steps back, magnitude clamped
	function automatic logic [8:0] back_idx(
		input logic [8:0] wp,
		input logic [8:0] mag
	);
		logic [8:0] m;
		m = (mag > cal_pkg::PHASE_MAX) ? cal_pkg::PHASE_MAX : mag;
		if (wp >= m)
			back_idx = wp - m;
		else
			back_idx = 9'(wp + 9'(cal_pkg::PHASE_DEPTH) - m);
	endfunction : back_idx

	// ------------------------------------------------------------
	// phase history memory
	// ------------------------------------------------------------
	assign tick = (s_q.div == 8'(cal_pkg::STEP_CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (tick)
			hist[s_q.wp] <= {gain_apply(wave_i.cur_a, s_q.regs.igain_a),
				gain_apply(wave_i.cur_b, s_q.regs.igain_b), wave_i.volt};
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [9:0]           idx;
		logic                 req;
		logic [23:0]          rd;
		logic [71:0]          ha;
		logic [71:0]          hb;
		logic signed [23:0]   ga;
		logic signed [23:0]   gb;
		s_d = s_q;
		idx = address_i[11:2];
		req = read_i | write_i;
		rd  = 24'h0;
		ha  = hist[back_idx(s_q.wp, s_q.regs.phase_a[8:0])];
		hb  = hist[back_idx(s_q.wp, s_q.regs.phase_b[8:0])];
		ga  = gain_apply(wave_i.cur_a, s_q.regs.igain_a);
		gb  = gain_apply(wave_i.cur_b, s_q.regs.igain_b);

		// bus slave: one wait cycle, then commit
		if (req && !s_q.wait_n) begin
			s_d.wait_n = 1'b1;
			unique case (idx)
				cal_pkg::IDX_PHASE_A:   rd = {14'h0, s_q.regs.phase_a};
				cal_pkg::IDX_PHASE_B:   rd = {14'h0, s_q.regs.phase_b};
				cal_pkg::IDX_IGAIN_A:   rd = s_q.regs.igain_a;
				cal_pkg::IDX_VGAIN_1:   rd = s_q.regs.vgain_1;
				cal_pkg::IDX_WGAIN_A:   rd = s_q.regs.wgain_a;
				cal_pkg::IDX_VARGAIN_A: rd = s_q.regs.vargain_a;
				cal_pkg::IDX_VAGAIN_A:  rd = s_q.regs.vagain_a;
				cal_pkg::IDX_IRMSOS_A:  rd = s_q.regs.irmsos_a;
				cal_pkg::IDX_VOLTAGE_RMS_OFFSET:    rd = s_q.regs.voltage_rms_offset;
				cal_pkg::IDX_WOS_A:     rd = s_q.regs.wos_a;
				cal_pkg::IDX_VAROS_A:   rd = s_q.regs.varos_a;
				cal_pkg::IDX_VAOS_A:    rd = s_q.regs.vaos_a;
				cal_pkg::IDX_IGAIN_B:   rd = s_q.regs.igain_b;
				cal_pkg::IDX_VGAIN_2:   rd = s_q.regs.vgain_2;
				cal_pkg::IDX_WGAIN_B:   rd = s_q.regs.wgain_b;
				cal_pkg::IDX_VARGAIN_B: rd = s_q.regs.vargain_b;
				cal_pkg::IDX_VAGAIN_B:  rd = s_q.regs.vagain_b;
				cal_pkg::IDX_IRMSOS_B:  rd = s_q.regs.irmsos_b;
				cal_pkg::IDX_WOS_B:     rd = s_q.regs.wos_b;
				cal_pkg::IDX_VAROS_B:   rd = s_q.regs.varos_b;
				cal_pkg::IDX_VAOS_B:    rd = s_q.regs.vaos_b;
				cal_pkg::IDX_STATUS:    rd = {s_q.pcount[14:0], s_q.wp};
				default:                rd = 24'h0;
			endcase
			if (read_i)
				s_d.rdata = {8'h0, rd};
		end else if (req) begin
			s_d.wait_n = 1'b0;
			if (write_i) begin
				unique case (idx)
					cal_pkg::IDX_PHASE_A: begin
						if (byteenable_i[0])
							s_d.regs.phase_a[7:0] = writedata_i[7:0];
						if (byteenable_i[1])
							s_d.regs.phase_a[9:8] = writedata_i[9:8];
					end
					cal_pkg::IDX_PHASE_B: begin
						if (byteenable_i[0])
							s_d.regs.phase_b[7:0] = writedata_i[7:0];
						if (byteenable_i[1])
							s_d.regs.phase_b[9:8] = writedata_i[9:8];
					end
					cal_pkg::IDX_IGAIN_A: s_d.regs.igain_a =
						be_merge(s_q.regs.igain_a, writedata_i, byteenable_i);
					cal_pkg::IDX_VGAIN_1: s_d.regs.vgain_1 =
						be_merge(s_q.regs.vgain_1, writedata_i, byteenable_i);
					cal_pkg::IDX_WGAIN_A: s_d.regs.wgain_a =
						be_merge(s_q.regs.wgain_a, writedata_i, byteenable_i);
					cal_pkg::IDX_VARGAIN_A: s_d.regs.vargain_a =
						be_merge(s_q.regs.vargain_a, writedata_i, byteenable_i);
					cal_pkg::IDX_VAGAIN_A: s_d.regs.vagain_a =
						be_merge(s_q.regs.vagain_a, writedata_i, byteenable_i);
					cal_pkg::IDX_IRMSOS_A: s_d.regs.irmsos_a =
						be_merge(s_q.regs.irmsos_a, writedata_i, byteenable_i);
					cal_pkg::IDX_VOLTAGE_RMS_OFFSET: s_d.regs.voltage_rms_offset =
						be_merge(s_q.regs.voltage_rms_offset, writedata_i, byteenable_i);
					cal_pkg::IDX_WOS_A: s_d.regs.wos_a =
						be_merge(s_q.regs.wos_a, writedata_i, byteenable_i);
					cal_pkg::IDX_VAROS_A: s_d.regs.varos_a =
						be_merge(s_q.regs.varos_a, writedata_i, byteenable_i);
					cal_pkg::IDX_VAOS_A: s_d.regs.vaos_a =
						be_merge(s_q.regs.vaos_a, writedata_i, byteenable_i);
					cal_pkg::IDX_IGAIN_B: s_d.regs.igain_b =
						be_merge(s_q.regs.igain_b, writedata_i, byteenable_i);
					cal_pkg::IDX_VGAIN_2: s_d.regs.vgain_2 =
						be_merge(s_q.regs.vgain_2, writedata_i, byteenable_i);
					cal_pkg::IDX_WGAIN_B: s_d.regs.wgain_b =
						be_merge(s_q.regs.wgain_b, writedata_i, byteenable_i);
					cal_pkg::IDX_VARGAIN_B: s_d.regs.vargain_b =
						be_merge(s_q.regs.vargain_b, writedata_i, byteenable_i);
					cal_pkg::IDX_VAGAIN_B: s_d.regs.vagain_b =
						be_merge(s_q.regs.vagain_b, writedata_i, byteenable_i);
					cal_pkg::IDX_IRMSOS_B: s_d.regs.irmsos_b =
						be_merge(s_q.regs.irmsos_b, writedata_i, byteenable_i);
					cal_pkg::IDX_WOS_B: s_d.regs.wos_b =
						be_merge(s_q.regs.wos_b, writedata_i, byteenable_i);
					cal_pkg::IDX_VAROS_B: s_d.regs.varos_b =
						be_merge(s_q.regs.varos_b, writedata_i, byteenable_i);
					cal_pkg::IDX_VAOS_B: s_d.regs.vaos_b =
						be_merge(s_q.regs.vaos_b, writedata_i, byteenable_i);
					default: ;
				endcase
			end
		end else begin
			s_d.wait_n = 1'b0;
		end

		// power calibration, channel A and B each with own set
		s_d.pvalid = power_valid_i;
		if (power_valid_i) begin
			s_d.pcount = 16'(s_q.pcount + 16'h1);
			s_d.pa.active = offset_apply(
				gain_apply(power_a_i.active, s_q.regs.wgain_a),
				s_q.regs.wos_a);
			s_d.pa.reactive = offset_apply(
				gain_apply(power_a_i.reactive, s_q.regs.vargain_a),
				s_q.regs.varos_a);
			s_d.pa.apparent = offset_apply(
				gain_apply(power_a_i.apparent, s_q.regs.vagain_a),
				s_q.regs.vaos_a);
			s_d.pb.active = offset_apply(
				gain_apply(power_b_i.active, s_q.regs.wgain_b),
				s_q.regs.wos_b);
			s_d.pb.reactive = offset_apply(
				gain_apply(power_b_i.reactive, s_q.regs.vargain_b),
				s_q.regs.varos_b);
			s_d.pb.apparent = offset_apply(
				gain_apply(power_b_i.apparent, s_q.regs.vagain_b),
				s_q.regs.vaos_b);
		end

		// rms: only the first voltage gain is used
		s_d.rvalid = rms_valid_i;
		if (rms_valid_i) begin
			s_d.rms.volt = rms_cal(rms_sq_i.volt, s_q.regs.voltage_rms_offset,
				s_q.regs.vgain_1);
			s_d.rms.cur_a = rms_cal(rms_sq_i.cur_a, s_q.regs.irmsos_a,
				s_q.regs.igain_a);
			s_d.rms.cur_b = rms_cal(rms_sq_i.cur_b, s_q.regs.irmsos_b,
				s_q.regs.igain_b);
		end

		// phase trim: delay takes old current, advance takes old voltage
		s_d.div    = tick ? 8'h0 : 8'(s_q.div + 8'h1);
		s_d.wvalid = tick;
		if (tick) begin
			s_d.wp = (s_q.wp == 9'(cal_pkg::PHASE_DEPTH - 1)) ? 9'h0
				: 9'(s_q.wp + 9'h1);
			s_d.wa = '{cur_a: ga, cur_b: gb, volt: wave_i.volt};
			s_d.wb = '{cur_a: ga, cur_b: gb, volt: wave_i.volt};
			if (s_q.regs.phase_a[8:0] != 9'h0) begin
				if (!s_q.regs.phase_a[cal_pkg::PHASE_MSB])
					s_d.wa.cur_a = ha[71:48];
				else
					s_d.wa.volt = ha[23:0];
			end
			if (s_q.regs.phase_b[8:0] != 9'h0) begin
				if (!s_q.regs.phase_b[cal_pkg::PHASE_MSB])
					s_d.wb.cur_b = hb[47:24];
				else
					s_d.wb.volt = hb[23:0];
			end
		end

		if (rst_i) begin
			s_d = '0;
			s_d.regs.phase_a   = cal_pkg::PHASE_RESET;
			s_d.regs.phase_b   = cal_pkg::PHASE_RESET;
			s_d.regs.igain_a   = cal_pkg::GAIN_UNITY;
			s_d.regs.vgain_1   = cal_pkg::GAIN_UNITY;
			s_d.regs.wgain_a   = cal_pkg::GAIN_UNITY;
			s_d.regs.vargain_a = cal_pkg::GAIN_UNITY;
			s_d.regs.vagain_a  = cal_pkg::GAIN_UNITY;
			s_d.regs.irmsos_a  = cal_pkg::OFS_RESET;
			s_d.regs.voltage_rms_offset    = cal_pkg::OFS_RESET;
			s_d.regs.wos_a     = cal_pkg::OFS_RESET;
			s_d.regs.varos_a   = cal_pkg::OFS_RESET;
			s_d.regs.vaos_a    = cal_pkg::OFS_RESET;
			s_d.regs.igain_b   = cal_pkg::GAIN_UNITY;
			s_d.regs.vgain_2   = cal_pkg::GAIN_UNITY;
			s_d.regs.wgain_b   = cal_pkg::GAIN_UNITY;
			s_d.regs.vargain_b = cal_pkg::GAIN_UNITY;
			s_d.regs.vagain_b  = cal_pkg::GAIN_UNITY;
			s_d.regs.irmsos_b  = cal_pkg::OFS_RESET;
			s_d.regs.wos_b     = cal_pkg::OFS_RESET;
			s_d.regs.varos_b   = cal_pkg::OFS_RESET;
			s_d.regs.vaos_b    = cal_pkg::OFS_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		s_q <= s_d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign readdata_o    = s_q.rdata;
	assign waitrequest_o = ~s_q.wait_n;
	assign power_a_o     = s_q.pa;
	assign power_b_o     = s_q.pb;
	assign power_valid_o = s_q.pvalid;
	assign rms_o         = s_q.rms;
	assign rms_valid_o   = s_q.rvalid;
	assign wave_a_o      = s_q.wa;
	assign wave_b_o      = s_q.wb;
	assign wave_valid_o  = s_q.wvalid;

endmodule : energy_meter_calibration

//--- tb/energy_meter_calibration_monitor.sv
// port-level assertion checker for the calibration datapath
`timescale 1ns/1ps
module energy_meter_calibration_monitor (
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic [11:0]      address_i,
	input wire logic             read_i,
	input wire logic             write_i,
	input wire logic [31:0]      writedata_i,
	input wire logic [3:0]       byteenable_i,
	input wire logic [31:0]      readdata_o,
	input wire logic             waitrequest_o,
	input wire cal_pkg::power_t  power_a_i,
	input wire cal_pkg::power_t  power_b_i,
	input wire logic             power_valid_i,
	input wire cal_pkg::power_t  power_a_o,
	input wire cal_pkg::power_t  power_b_o,
	input wire logic             power_valid_o,
	input wire cal_pkg::rms_sq_t rms_sq_i,
	input wire logic             rms_valid_i,
	input wire cal_pkg::rms_t    rms_o,
	input wire logic             rms_valid_o,
	input wire cal_pkg::wave_t   wave_i,
	input wire cal_pkg::wave_t   wave_a_o,
	input wire cal_pkg::wave_t   wave_b_o,
	input wire logic             wave_valid_o
);
	// ----------------------------------------
	// coefficients untouched since reset
	// ----------------------------------------
	logic dflt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dflt_q <= 1'b1;
		end else if (write_i && !waitrequest_o) begin
			dflt_q <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	power_pulse_a: assert property (power_valid_i |=> power_valid_o)
		else $error("power valid not one cycle after input");
	power_hold_a: assert property (!power_valid_o |-> $stable(power_a_o)
		&& $stable(power_b_o)) else $error("power output moved");
	unity_power_a: assert property (dflt_q && power_valid_i |=>
		power_a_o == $past(power_a_i) && power_b_o == $past(power_b_i))
		else $error("reset gain or offset not neutral");
	rms_pulse_a: assert property (rms_valid_i |=> rms_valid_o)
		else $error("rms valid not one cycle after input");
	rms_root_a: assert property (dflt_q && rms_valid_i |=>
		49'(rms_o.volt) * 49'(rms_o.volt) <= 49'($past(rms_sq_i.volt)) &&
		(49'(rms_o.volt) + 49'h1) * (49'(rms_o.volt) + 49'h1) >
		49'($past(rms_sq_i.volt))) else $error("voltage rms not a root");
	wave_tick_a: assert property (wave_valid_o |=>
		(!wave_valid_o)[*8] ##131 wave_valid_o)
		else $error("wave tick spacing wrong");
	wave_hold_a: assert property (!wave_valid_o |-> $stable(wave_a_o)
		&& $stable(wave_b_o)) else $error("wave output moved");
	bus_answer_a: assert property ((read_i || write_i) && waitrequest_o
		|=> !waitrequest_o) else $error("bus answer late");
	bus_single_a: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("answer longer than one cycle");
	read_stand_a: assert property ($changed(readdata_o) |->
		read_i && !waitrequest_o) else $error("read data moved");

	cover property (power_valid_o && !dflt_q);
	cover property (read_i && !waitrequest_o);
	cover property (wave_valid_o);
	cover property (rms_valid_o);
endmodule : energy_meter_calibration_monitor

bind energy_meter_calibration energy_meter_calibration_monitor i_mon (
	.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
	.write_i(write_i), .writedata_i(writedata_i),
	.byteenable_i(byteenable_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o), .power_a_i(power_a_i),
	.power_b_i(power_b_i), .power_valid_i(power_valid_i),
	.power_a_o(power_a_o), .power_b_o(power_b_o),
	.power_valid_o(power_valid_o), .rms_sq_i(rms_sq_i),
	.rms_valid_i(rms_valid_i), .rms_o(rms_o), .rms_valid_o(rms_valid_o),
	.wave_i(wave_i), .wave_a_o(wave_a_o), .wave_b_o(wave_b_o),
	.wave_valid_o(wave_valid_o)
);

//--- tb/tb_top.sv
// self-checking bench for the calibration datapath
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [9:0]      idx;
		logic [23:0]     val;
		cal_pkg::power_t ea;
		cal_pkg::power_t eb;
	} row_t;

	localparam cal_pkg::power_t IN_A = 72'h001000000800002000;
	localparam cal_pkg::power_t IN_B = 72'hfff0000008007fffff;
	localparam row_t ROWS [11] = '{
	'{10'h100, 24'h123456, 72'h001000000800002000, 72'hfff0000008007fffff},
	'{10'h282, 24'h600000, 72'h001800000800002000, 72'hfff0000008007fffff},
	'{10'h28f, 24'h200000, 72'h001800000800002000, 72'hfff0000004007fffff},
	'{10'h284, 24'h200000, 72'h001800000800001000, 72'hfff0000004007fffff},
	'{10'h295, 24'h000400, 72'h001800000800001000, 72'hfff0020004007fffff},
	'{10'h28a, 24'hfffe00, 72'h0018000007ff001000, 72'hfff0020004007fffff},
	'{10'h297, 24'h000200, 72'h0018000007ff001000, 72'hfff0020004007fffff},
	'{10'h28e, 24'h600000, 72'h0018000007ff001000, 72'hffe8020004007fffff},
	'{10'h290, 24'h200000, 72'h0018000007ff001000, 72'hffe802000400400000},
	'{10'h283, 24'h600000, 72'h001800000bff001000, 72'hffe802000400400000},
	'{10'h289, 24'hffffff, 72'h0017ff000bff001000, 72'hffe802000400400000}};

	logic             clk_i;
	logic             rst_i;
	logic [11:0]      address_i;
	logic             read_i;
	logic             write_i;
	logic [31:0]      writedata_i;
	logic [3:0]       byteenable_i;
	logic [31:0]      readdata_o;
	logic             waitrequest_o;
	cal_pkg::power_t  power_a_i;
	cal_pkg::power_t  power_b_i;
	logic             power_valid_i;
	cal_pkg::power_t  power_a_o;
	cal_pkg::power_t  power_b_o;
	logic             power_valid_o;
	cal_pkg::rms_sq_t rms_sq_i;
	logic             rms_valid_i;
	cal_pkg::rms_t    rms_o;
	logic             rms_valid_o;
	cal_pkg::wave_t   wave_i;
	cal_pkg::wave_t   wave_a_o;
	cal_pkg::wave_t   wave_b_o;
	logic             wave_valid_o;
	logic [31:0]      rd;
	int               fail_count;
	int               checks;

	energy_meter_calibration i_energy_meter_calibration (
		.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .power_a_i(power_a_i),
		.power_b_i(power_b_i), .power_valid_i(power_valid_i),
		.power_a_o(power_a_o), .power_b_o(power_b_o),
		.power_valid_o(power_valid_o), .rms_sq_i(rms_sq_i),
		.rms_valid_i(rms_valid_i), .rms_o(rms_o), .rms_valid_o(rms_valid_o),
		.wave_i(wave_i), .wave_a_o(wave_a_o), .wave_b_o(wave_b_o),
		.wave_valid_o(wave_valid_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [71:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	// bounded wait, sampled mid-cycle; sel picks the watched output
	task automatic wait_for(input int sel, input logic lvl);
		int   n;
		logic v;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
			v = (sel == 0) ? waitrequest_o : (sel == 1) ? power_valid_o
				: (sel == 2) ? rms_valid_o : wave_valid_o;
		end while (v !== lvl && n < 300);
		if (v !== lvl) begin
			fail_count++;
			print_verdict();
		end
	endtask : wait_for

	task automatic bus(input logic wr, input logic [9:0] idx,
		input logic [23:0] wd);
		@(posedge clk_i);
		read_i      <= !wr;
		write_i     <= wr;
		address_i   <= {idx, 2'b00};
		writedata_i <= {8'hff, wd};
		wait_for(0, 1'b0);
		rd = readdata_o;
		@(posedge clk_i);
		read_i  <= 1'b0;
		write_i <= 1'b0;
	endtask : bus

	task automatic power_pulse(input cal_pkg::power_t ea, eb);
		@(posedge clk_i);
		power_valid_i <= 1'b1;
		@(posedge clk_i);
		power_valid_i <= 1'b0;
		wait_for(1, 1'b1);
		check("power_a", power_a_o, ea);
		check("power_b", power_b_o, eb);
	endtask : power_pulse

	task automatic rms_pulse(input cal_pkg::rms_t e);
		@(posedge clk_i);
		rms_valid_i <= 1'b1;
		@(posedge clk_i);
		rms_valid_i <= 1'b0;
		wait_for(2, 1'b1);
		check("rms", rms_o, e);
	endtask : rms_pulse

	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : do_reset

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst_i, read_i, write_i, power_valid_i, rms_valid_i} = 5'h10;
		address_i    = 12'h000;
		writedata_i  = 32'h00000000;
		byteenable_i = 4'hf;
		power_a_i    = IN_A;
		power_b_i    = IN_B;
		rms_sq_i     = {3{48'h000000002710}};
		wave_i       = 72'h0;
		fail_count   = 0;
		checks       = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 11; i++) begin
			bus(1'b1, ROWS[i].idx, ROWS[i].val);
			bus(1'b0, ROWS[i].idx, 24'h000000);
			check("readback", {40'h0, rd},
				{48'h0, (ROWS[i].idx == 10'h100) ? 24'h0 : ROWS[i].val});
			power_pulse(ROWS[i].ea, ROWS[i].eb);
		end
		do_reset();
		bus(1'b0, 10'h28e, 24'h000000);
		check("gain_reset", {40'h0, rd}, 72'h400000);
		bus(1'b0, 10'h295, 24'h000000);
		check("offset_reset", {40'h0, rd}, 72'h0);
		power_pulse(IN_A, IN_B);
		rms_pulse(72'h000064000064000064);
		bus(1'b1, 10'h288, 24'h000001);
		bus(1'b1, 10'h286, 24'hffffff);
		bus(1'b1, 10'h280, 24'h600000);
		bus(1'b1, 10'h28c, 24'h200000);
		bus(1'b1, 10'h28d, 24'h200000);
		rms_pulse(72'h000076000072000032);
		bus(1'b1, 10'h108, 24'h000001);
		bus(1'b1, 10'h109, 24'h000201);
		wait_for(3, 1'b1);
		@(posedge clk_i);
		wave_i <= 72'h000100000100000111;
		wait_for(3, 1'b1);
		@(posedge clk_i);
		wave_i <= 72'h000200000200000222;
		wait_for(3, 1'b1);
		check("delay_cur", {48'h0, wave_a_o.cur_a}, 72'h180);
		check("delay_volt", {48'h0, wave_a_o.volt}, 72'h222);
		check("adv_cur", {48'h0, wave_b_o.cur_b}, 72'h100);
		check("adv_volt", {48'h0, wave_b_o.volt}, 72'h111);
		print_verdict();
	end
endmodule : tb_top
